// ### verilog/mist_exec.sv
`timescale 1ns/100ps
`include "mist_defs.svh"
// Behaviour
// - nibble swap exchanges the halves of the addressed register and writes the accumulator (d=0) or the register (d=1) in one cycle, flags untouched.
// - the high-byte table read loads the accumulator with the upper bits of the ROM word at the table pointer over two cycles.
// - the low-byte table read loads the accumulator with bits 7..0 of the ROM word at the table pointer over two cycles.
// - the table pointer is the low four bits of the pointer-high register above the indirect-address register's eight bits.
// - ROM words are 14 bits, the low read gives bits 7..0 and the high read the bits above.
// - zero test sets the zero flag when the addressed register is zero and changes nothing else.
// - literal XOR puts accumulator XOR literal into the accumulator and updates zero in one cycle.
// - register XOR puts accumulator XOR register into the accumulator or register and updates zero in one cycle.
module mist_exec #(
    parameter int ROM_AW = `MIST_ROM_AW
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic clkEn,
    input wire logic insnValid,
    input wire logic [`MIST_ROM_W-1:0] insnWord,
    output logic insnReady,
    output logic [`MIST_FILE_AW-1:0] fileAddr,
    input wire logic [`MIST_BYTE_W-1:0] fileRdata,
    output logic fileWe,
    output logic [`MIST_FILE_AW-1:0] fileWaddr,
    output logic [`MIST_BYTE_W-1:0] fileWdata,
    input wire logic [`MIST_BYTE_W-1:0] pointerHighReg,
    input wire logic [`MIST_BYTE_W-1:0] indirectAddressReg,
    output logic romRd,
    output logic [ROM_AW-1:0] romAddr,
    input wire logic [`MIST_ROM_W-1:0] romData,
    output logic [`MIST_BYTE_W-1:0] acc,
    output logic zeroFlag,
    output logic busy
);
    logic [`MIST_BYTE_W-1:0] acc_r, acc_nxt;
    logic zero_r, zero_nxt;
    logic fileWe_r, fileWe_nxt;
    logic [`MIST_FILE_AW-1:0] fileWaddr_r;
    logic [`MIST_BYTE_W-1:0] fileWdata_r, fileWdata_nxt;
    logic romRd_r;
    logic [ROM_AW-1:0] romAddr_r;
    logic tabHigh_r;
    mist_pkg::mist_state_t state_r, state_nxt;

    wire logic dBit = insnWord[`MIST_DEST_BIT];
    wire logic [`MIST_ROM_W-`MIST_BYTE_W-1:0] opHi = insnWord[`MIST_ROM_W-1:`MIST_BYTE_W];
    wire logic [`MIST_ROM_W-`MIST_DEST_BIT-1:0] opHiTest = insnWord[`MIST_ROM_W-1:`MIST_DEST_BIT];
    wire logic [`MIST_FILE_AW-1:0] opFile = insnWord[`MIST_FILE_AW-1:0];
    wire logic [`MIST_BYTE_W-1:0] opLit = insnWord[`MIST_BYTE_W-1:0];
    wire logic [`MIST_BYTE_W-1:0] swapVal = {fileRdata[`MIST_NIB_W-1:0],
        fileRdata[`MIST_BYTE_W-1:`MIST_NIB_W]};
    wire logic [`MIST_BYTE_W-1:0] xorFVal = acc_r ^ fileRdata;
    wire logic [`MIST_BYTE_W-1:0] xorLVal = acc_r ^ opLit;
    // table pointer: high register supplies bits above 7, truncated to the ROM width
    wire logic [2*`MIST_BYTE_W-1:0] ptrFull = {pointerHighReg, indirectAddressReg};
    wire logic [ROM_AW-1:0] tabPtr = ptrFull[ROM_AW-1:0];
    wire logic [`MIST_BYTE_W-1:0] romHigh = {{(2*`MIST_BYTE_W-`MIST_ROM_W){1'b0}},
        romData[`MIST_ROM_W-1:`MIST_BYTE_W]};
    wire logic [`MIST_BYTE_W-1:0] romLow = romData[`MIST_BYTE_W-1:0];

    mist_pkg::mist_op_t op;
    assign op = (opHi == `MIST_OP_SWAP_HI) ? mist_pkg::MIST_SWAP :
                (opHi == `MIST_OP_XORF_HI) ? mist_pkg::MIST_XORF :
                (opHi == `MIST_OP_XORL_HI) ? mist_pkg::MIST_XORL :
                (opHiTest == `MIST_OP_TEST_HI) ? mist_pkg::MIST_TEST :
                (insnWord == `MIST_OP_TABH) ? mist_pkg::MIST_TABH :
                (insnWord == `MIST_OP_TABL) ? mist_pkg::MIST_TABL : mist_pkg::MIST_NONE;

    wire logic inExec = (state_r == mist_pkg::MIST_EXEC);
    wire logic take = clkEn && insnValid && inExec;
    wire logic isTab = (op == mist_pkg::MIST_TABH) || (op == mist_pkg::MIST_TABL);

    assign insnReady = inExec;
    assign fileAddr = opFile;
    assign acc = acc_r;
    assign zeroFlag = zero_r;
    assign fileWe = fileWe_r;
    assign fileWaddr = fileWaddr_r;
    assign fileWdata = fileWdata_r;
    assign romRd = romRd_r;
    assign romAddr = romAddr_r;
    assign busy = !inExec;

    always_comb begin
        acc_nxt = acc_r;
        zero_nxt = zero_r;
        fileWe_nxt = 1'b0;
        fileWdata_nxt = fileWdata_r;
        state_nxt = state_r;
        case (state_r)
            mist_pkg::MIST_EXEC: begin
                if (insnValid) begin
                    case (op)
                        mist_pkg::MIST_SWAP: begin
                            if (dBit) begin
                                fileWe_nxt = 1'b1;
                                fileWdata_nxt = swapVal;
                            end else begin
                                acc_nxt = swapVal;
                            end
                        end
                        mist_pkg::MIST_XORF: begin
                            if (dBit) begin
                                fileWe_nxt = 1'b1;
                                fileWdata_nxt = xorFVal;
                            end else begin
                                acc_nxt = xorFVal;
                            end
                            zero_nxt = (xorFVal == `MIST_ACC_RST);
                        end
                        mist_pkg::MIST_XORL: begin
                            acc_nxt = xorLVal;
                            zero_nxt = (xorLVal == `MIST_ACC_RST);
                        end
                        mist_pkg::MIST_TEST: zero_nxt = (fileRdata == `MIST_ACC_RST);
                        mist_pkg::MIST_TABH, mist_pkg::MIST_TABL: state_nxt = mist_pkg::MIST_FETCH;
                        default: ;
                    endcase
                end
            end
            mist_pkg::MIST_FETCH: begin
                // second cycle: the partner drives the ROM word for the registered romAddr onto romData without a clock
                acc_nxt = tabHigh_r ? romHigh : romLow;
                state_nxt = mist_pkg::MIST_EXEC;
            end
            default: state_nxt = mist_pkg::MIST_EXEC;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            acc_r <= `MIST_ACC_RST;
            zero_r <= 1'b0;
            fileWe_r <= 1'b0;
            fileWaddr_r <= '0;
            fileWdata_r <= `MIST_ACC_RST;
            romRd_r <= 1'b0;
            romAddr_r <= '0;
            tabHigh_r <= 1'b0;
            state_r <= mist_pkg::MIST_EXEC;
        end else if (clkEn) begin
            acc_r <= acc_nxt;
            zero_r <= zero_nxt;
            fileWe_r <= fileWe_nxt;
            fileWdata_r <= fileWdata_nxt;
            state_r <= state_nxt;
            if (take) begin
                fileWaddr_r <= opFile;
            end
            romRd_r <= take && isTab;
            if (take && isTab) begin
                romAddr_r <= tabPtr;
                tabHigh_r <= (op == mist_pkg::MIST_TABH);
            end
        end
    end

    // results land on the taking edge, so a freeze in the cycle after it cannot trip these checks
    property p_swap_acc;
        @(posedge clk) disable iff (!resetn)
        (take && op == mist_pkg::MIST_SWAP && !dBit) |=> (acc_r == $past(swapVal));
    endproperty
    a_swap_acc: assert property (p_swap_acc) else $error("swap to accumulator wrong");

    property p_swap_noflag;
        @(posedge clk) disable iff (!resetn)
        (take && op == mist_pkg::MIST_SWAP) |=> $stable(zero_r);
    endproperty
    a_swap_noflag: assert property (p_swap_noflag) else $error("swap changed zero flag");

    sequence s_tab_start(bit hi);
        take && isTab && ((op == mist_pkg::MIST_TABH) == hi);
    endsequence
    property p_tabh;
        @(posedge clk) disable iff (!resetn)
        s_tab_start(1'b1) ##1 clkEn |=> (acc_r == `MIST_BYTE_W'($past(romData[`MIST_ROM_W-1:`MIST_BYTE_W])));
    endproperty
    a_tabh: assert property (p_tabh) else $error("high table read wrong");

    property p_tabl;
        @(posedge clk) disable iff (!resetn)
        s_tab_start(1'b0) ##1 clkEn |=> (acc_r == $past(romData[`MIST_BYTE_W-1:0]));
    endproperty
    a_tabl: assert property (p_tabl) else $error("low table read wrong");

    property p_tab_addr;
        @(posedge clk) disable iff (!resetn)
        (take && isTab) |=> (romRd && romAddr == $past(tabPtr) && busy);
    endproperty
    a_tab_addr: assert property (p_tab_addr) else $error("table address wrong");

    property p_high_bits;
        @(posedge clk) disable iff (!resetn)
        s_tab_start(1'b1) ##1 clkEn |=> (acc_r[`MIST_BYTE_W-1:`MIST_ROM_W-`MIST_BYTE_W] == '0);
    endproperty
    a_high_bits: assert property (p_high_bits) else $error("high byte wider than ROM");

    property p_test;
        @(posedge clk) disable iff (!resetn)
        (take && op == mist_pkg::MIST_TEST) |=> (zero_r == ($past(fileRdata) == '0)) && $stable(acc_r) && !fileWe;
    endproperty
    a_test: assert property (p_test) else $error("zero test wrong");

    property p_xorl;
        @(posedge clk) disable iff (!resetn)
        (take && op == mist_pkg::MIST_XORL) |=> (acc_r == ($past(acc_r) ^ $past(opLit)));
    endproperty
    a_xorl: assert property (p_xorl) else $error("literal xor wrong");

    property p_xorf_reg;
        @(posedge clk) disable iff (!resetn)
        (take && op == mist_pkg::MIST_XORF && dBit) |=> (fileWe && fileWdata == $past(xorFVal)
            && fileWaddr == $past(opFile) && $stable(acc_r));
    endproperty
    a_xorf_reg: assert property (p_xorf_reg) else $error("register xor wrong");

    property p_zero;
        @(posedge clk) disable iff (!resetn)
        (take && (op == mist_pkg::MIST_XORF || op == mist_pkg::MIST_XORL)) |=>
            (zero_r == ($past(op == mist_pkg::MIST_XORF ? xorFVal : xorLVal) == '0));
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");

    property p_operand;
        @(posedge clk) disable iff (!resetn)
        (take && op == mist_pkg::MIST_SWAP && dBit) |=>
            (fileWe && fileWaddr == $past(insnWord[`MIST_FILE_AW-1:0])
            && fileWdata == {$past(fileRdata[`MIST_NIB_W-1:0]), $past(fileRdata[`MIST_BYTE_W-1:`MIST_NIB_W])});
    endproperty
    a_operand: assert property (p_operand) else $error("operand select wrong");
endmodule : mist_exec

// ### verilog/mist_defs.svh
`ifndef MIST_DEFS_SVH
`define MIST_DEFS_SVH
// opcode patterns (14-bit words)
`define MIST_OP_SWAP_HI 6'h0e
`define MIST_OP_XORF_HI 6'h06
`define MIST_OP_TEST_HI 7'h11
`define MIST_OP_XORL_HI 6'h1f
`define MIST_OP_TABH 14'h0058
`define MIST_OP_TABL 14'h0050
`define MIST_ROM_W 14
`define MIST_ROM_AW 12
`define MIST_FILE_AW 7
`define MIST_BYTE_W 8
`define MIST_DEST_BIT 7
`define MIST_NIB_W 4
`define MIST_ACC_RST 8'h00
`endif

// ### verilog/mist_pkg.sv
package mist_pkg;
    typedef enum logic [2:0] {MIST_NONE, MIST_SWAP, MIST_XORF, MIST_XORL, MIST_TEST, MIST_TABH, MIST_TABL}
        mist_op_t;
    typedef enum logic {MIST_EXEC, MIST_FETCH} mist_state_t;
endpackage : mist_pkg

// ### verif/mist_rom_model.sv
`timescale 1ns/100ps
module mist_rom_model (
    input wire logic clk,
    input wire logic romRd,
    input wire logic [11:0] romAddr,
    output logic [13:0] romData
);
    logic [13:0] junkR_r = 14'h1555;
    function automatic logic [13:0] rom_word(input logic [11:0] a);
        return {a[11:6] ^ a[5:0], a[7:0] ^ 8'h5a};
    endfunction : rom_word
    // between reads the bus shows a pattern that moves every cycle, so a late sample cannot match by luck
    always_ff @(posedge clk) begin
        junkR_r <= ~junkR_r + 14'h0001;
    end
    assign romData = romRd ? rom_word(romAddr) : junkR_r;
endmodule : mist_rom_model

// ### verif/test_mcu_insn_swap_table_xor.sv
`timescale 1ns/100ps
`include "mist_defs.svh"
module test_mcu_insn_swap_table_xor;
    logic clk, resetn, clkEn, freeze, insnValid, insnReady, fileWe, romRd, zeroFlag, busy, mZero;
    logic [13:0] insnWord, romData;
    logic [6:0] fileAddr, fileWaddr;
    logic [7:0] fileRdata, fileWdata, pointerHighReg, indirectAddressReg, acc, mAcc;
    logic [11:0] romAddr;
    logic [7:0] regs [128];
    logic [31:0] seed = 32'd26358;
    logic [31:0] rv;
    int fails = 0;
    int samples_checked = 0;
    assign fileRdata = regs[fileAddr];
    mist_exec u_dut (.clk(clk), .resetn(resetn), .clkEn(clkEn), .insnValid(insnValid), .insnWord(insnWord),
        .insnReady(insnReady), .fileAddr(fileAddr), .fileRdata(fileRdata), .fileWe(fileWe),
        .fileWaddr(fileWaddr), .fileWdata(fileWdata), .pointerHighReg(pointerHighReg),
        .indirectAddressReg(indirectAddressReg), .romRd(romRd), .romAddr(romAddr), .romData(romData),
        .acc(acc), .zeroFlag(zeroFlag), .busy(busy));
    mist_rom_model u_rom (.clk(clk), .romRd(romRd), .romAddr(romAddr), .romData(romData));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    function automatic logic [31:0] xorshift();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xorshift
    task automatic chk(input string name, input logic [13:0] seen, input logic [13:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic complete_run();
        if (fails == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : complete_run
    task automatic exec(input logic [13:0] w);
        logic [7:0] r, res;
        logic [13:0] word;
        logic wr;
        r = regs[w[6:0]];
        res = mAcc;
        wr = 1'b0;
        @(posedge clk);
        #1;
        insnWord = w;
        insnValid = 1'b1;
        pointerHighReg = 8'(xorshift());
        indirectAddressReg = 8'(xorshift());
        word = u_rom.rom_word({pointerHighReg[3:0], indirectAddressReg});
        chk("insnReady", 14'(insnReady), 14'h0001);
        // a frozen edge with a request pending must leave the accumulator untouched and the unit idle
        if (freeze) begin
            clkEn = 1'b0;
            @(posedge clk);
            #1;
            clkEn = 1'b1;
            chk("acc", 14'(acc), 14'(mAcc));
            chk("busy", 14'(busy), 14'h0000);
        end
        @(posedge clk);
        #1;
        insnValid = 1'b0;
        if (w[13:8] == `MIST_OP_SWAP_HI) begin
            res = {r[3:0], r[7:4]};
            wr = 1'b1;
        end else if (w[13:8] == `MIST_OP_XORF_HI) begin
            res = mAcc ^ r;
            mZero = (res == 8'h00);
            wr = 1'b1;
        end else if (w[13:8] == `MIST_OP_XORL_HI) begin
            mAcc = mAcc ^ w[7:0];
            mZero = (mAcc == 8'h00);
        end else if (w[13:7] == `MIST_OP_TEST_HI) begin
            mZero = (r == 8'h00);
        end else if (w == `MIST_OP_TABH || w == `MIST_OP_TABL) begin
            chk("romRd", 14'(romRd), 14'h0001);
            chk("romAddr", 14'(romAddr), 14'({pointerHighReg[3:0], indirectAddressReg}));
            chk("busy", 14'(busy), 14'h0001);
            chk("insnReady", 14'(insnReady), 14'h0000);
            @(posedge clk);
            #1;
            mAcc = (w == `MIST_OP_TABH) ? {2'b00, word[13:8]} : word[7:0];
        end
        if (wr && w[7]) regs[w[6:0]] = res;
        else if (wr) mAcc = res;
        chk("fileWe", 14'(fileWe), 14'(wr && w[7]));
        if (wr && w[7]) begin
            chk("fileWaddr", 14'(fileWaddr), 14'(w[6:0]));
            chk("fileWdata", 14'(fileWdata), 14'(res));
        end
        chk("acc", 14'(acc), 14'(mAcc));
        chk("zeroFlag", 14'(zeroFlag), 14'(mZero));
    endtask : exec
    initial begin
        resetn = 1'b0;
        insnValid = 1'b0;
        clkEn = 1'b1;
        freeze = 1'b0;
        insnWord = 14'h0000;
        pointerHighReg = 8'h00;
        indirectAddressReg = 8'h00;
        mAcc = 8'h00;
        mZero = 1'b0;
        // a few zero registers so the zero test sees both outcomes
        for (int i = 0; i < 128; i++) regs[i] = (i < 4) ? 8'h00 : 8'(xorshift());
        repeat (8) @(posedge clk);
        #1;
        resetn = 1'b1;
        chk("acc", 14'(acc), 14'h0000);
        chk("romRd", 14'(romRd), 14'h0000);
        for (int n = 0; n < 300; n++) begin
            // a second reset in mid-run must bring back the idle state
            if (n == 150) begin
                resetn = 1'b0;
                repeat (2) @(posedge clk);
                #1;
                resetn = 1'b1;
                mAcc = 8'h00;
                mZero = 1'b0;
                chk("acc", 14'(acc), 14'h0000);
                chk("zeroFlag", 14'(zeroFlag), 14'h0000);
                chk("busy", 14'(busy), 14'h0000);
            end
            rv = xorshift();
            freeze = rv[21];
            if (rv[20]) rv[6:0] = {5'h00, rv[1:0]};
            case (rv[18:16] % 3'd7)
                3'd0: exec({`MIST_OP_SWAP_HI, rv[7:0]});
                3'd1: exec({`MIST_OP_XORF_HI, rv[7:0]});
                3'd2: exec({`MIST_OP_XORL_HI, rv[19] ? mAcc : rv[15:8]});
                3'd3: exec({`MIST_OP_TEST_HI, rv[6:0]});
                3'd4: exec(`MIST_OP_TABH);
                3'd5: exec(`MIST_OP_TABL);
                default: exec(14'h0000);
            endcase
        end
        complete_run();
    end
    initial begin
        repeat (2000) @(posedge clk);
        fails++;
        complete_run();
    end
endmodule : test_mcu_insn_swap_table_xor
